// [logic/mode_sequencer.v]
/*
 * Top-level operating-mode sequencer with its Wishbone register slave.
 * Assumes one 50 MHz clock, asynchronous active-high reset, classic
 * single-cycle Wishbone masters, and event inputs that are synchronous
 * one-cycle pulses or levels from the packet handler and FIFO logic.
 */
// Our own choice: the Wishbone interface to the registers.
`include "seq_regs.vh"

module mode_sequencer #(
   parameter [23:0] P_RES1_CYC = `T1_RES1_CYC,   // cycles per 64 us tick
   parameter [23:0] P_RES2_CYC = `T1_RES2_CYC,   // cycles per 4.1 ms tick
   parameter [23:0] P_RES3_CYC = `T1_RES3_CYC    // cycles per 262 ms tick
) (
   input  wire        I_CORE_CLK,
   input  wire        I_RESET,
   input  wire        I_WB_CYC,
   input  wire        I_WB_STB,
   input  wire        I_WB_WE,
   input  wire [7:0]  I_WB_ADR,
   input  wire [3:0]  I_WB_SEL,
   input  wire [31:0] I_WB_DAT,
   input  wire        I_FRAME_SENT_FLAG,
   input  wire        I_FRAME_BODY_COMPLETE,
   input  wire        I_CHECK_PASS_FLAG,
   input  wire        I_RSSI_FLAG,
   input  wire        I_SYNC_MATCH_FLAG,
   input  wire        I_LEAD_IN_FOUND_FLAG,
   input  wire        I_QUEUE_THRESHOLD_FLAG,
   output reg         O_WB_ACK,
   output reg  [31:0] O_WB_DAT,
   output reg  [2:0]  O_CHIP_MODE,
   output reg  [2:0]  O_SEQ_STATE
);

   // ------------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------------
   localparam [2:0] ST_OFF       = 3'h0;  // sequencer off, software owns mode
   localparam [2:0] ST_IDLE      = 3'h1;  // low-power rest, timer running
   localparam [2:0] ST_TX        = 3'h2;  // transmitting
   localparam [2:0] ST_RX        = 3'h3;  // receiving
   localparam [2:0] ST_PKT_RX    = 3'h4;  // packet received, holds
   localparam [2:0] ST_WAIT_FIFO = 3'h5;  // start pending on fifo level

   // ------------------------------------------------------------------
   // register state
   // ------------------------------------------------------------------
   reg  [5:0]  flow_pri_ff;     // stored bits 5..0 of primary control
   reg  [7:0]  flow_sec_ff;     // secondary control
   reg  [1:0]  tick_size_ff;    // first timer tick size
   reg  [7:0]  timer_coef_ff;   // first timer ticks per event
   reg  [2:0]  state_ff;        // sequencer state
   reg  [2:0]  mode_ff;         // chip mode
   reg  [2:0]  init_mode_ff;    // chip mode captured at start
   reg  [2:0]  nxt_state;
   reg  [2:0]  nxt_mode;
   reg  [2:0]  nxt_init_mode;
   reg  [31:0] nxt_rdata;       // read data mux
   wire        t1_evt;          // timer-one event pulse
   wire        bus_req;         // request present and not yet answered
   wire        wr_en;           // write commits at the ack edge
   wire        run_wr;          // run trigger written as one
   wire        halt_wr;         // halt trigger written as one

   // field aliases for readability
   wire        rest_depth_select = flow_pri_ff[`BIT_REST_DEPTH];
   wire [1:0]  launch_route      = flow_pri_ff[`LAUNCH_HI:`LAUNCH_LO];
   wire        low_energy_choice = flow_pri_ff[`BIT_LOW_ENERGY];
   wire        rest_exit_route   = flow_pri_ff[`BIT_REST_EXIT];
   wire        send_exit_route   = flow_pri_ff[`BIT_SEND_EXIT];
   wire [2:0]  listen_exit_route = flow_sec_ff[`LISTEN_HI:`LISTEN_LO];

   // ------------------------------------------------------------------
   // decode helpers, each used in several places
   // ------------------------------------------------------------------
   // byte address match for a register index
   function hit;
      input [7:0] adr;
      input [7:0] idx;
      begin
         hit = (adr == {idx[5:0], 2'b00});
      end
   endfunction

   // chip mode held while resting in Idle
   function [2:0] rest_mode;
      input depth;
      begin
         rest_mode = depth ? `MODE_SLEEP : `MODE_STANDBY;
      end
   endfunction

   // state entered by a low-power selection
   function [2:0] lp_state;
      input low;
      begin
         lp_state = low ? ST_IDLE : ST_OFF;
      end
   endfunction

   // chip mode entered by a low-power selection
   function [2:0] lp_mode;
      input       low;
      input       depth;
      input [2:0] init;
      begin
         lp_mode = low ? rest_mode(depth) : init;
      end
   endfunction

   // ------------------------------------------------------------------
   // first timer, runs only in Idle
   // ------------------------------------------------------------------
   first_timer #(
      .P_RES1_CYC (P_RES1_CYC),
      .P_RES2_CYC (P_RES2_CYC),
      .P_RES3_CYC (P_RES3_CYC)
   ) first_timer_inst (
      .i_clk       (I_CORE_CLK),
      .i_reset     (I_RESET),
      .i_run       (state_ff == ST_IDLE),
      .i_tick_size (tick_size_ff),
      .i_coef      (timer_coef_ff),
      .o_event     (t1_evt)
   );

   // ------------------------------------------------------------------
   // wishbone slave: ack one cycle after the request, writes at ack edge
   // ------------------------------------------------------------------
   assign bus_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   // only the low byte lane carries register data
   assign wr_en   = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_SEL[0];
   assign run_wr  = wr_en && hit(I_WB_ADR, `IDX_FLOW_PRI) && I_WB_DAT[`BIT_RUN];
   assign halt_wr = wr_en && hit(I_WB_ADR, `IDX_FLOW_PRI) && I_WB_DAT[`BIT_HALT];

   // read mux; triggers read zero, unmapped reads zero
   always @* begin
      nxt_rdata = 32'h00000000;
      if (hit(I_WB_ADR, `IDX_OP_MODE)) begin
         nxt_rdata[2:0] = mode_ff;
      end else if (hit(I_WB_ADR, `IDX_FLOW_PRI)) begin
         nxt_rdata[5:0] = flow_pri_ff;
      end else if (hit(I_WB_ADR, `IDX_FLOW_SEC)) begin
         nxt_rdata[7:0] = flow_sec_ff;
      end else if (hit(I_WB_ADR, `IDX_TIMER_RES)) begin
         nxt_rdata[`TICK_HI:`TICK_LO] = tick_size_ff;
      end else if (hit(I_WB_ADR, `IDX_TIMER_COEF)) begin
         nxt_rdata[7:0] = timer_coef_ff;
      end else if (hit(I_WB_ADR, `IDX_SEQ_STATUS)) begin
         nxt_rdata[5:0] = {mode_ff, state_ff};
      end
   end

   // ack pulse and registered read data
   always @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= bus_req;
         if (bus_req) begin
            O_WB_DAT <= nxt_rdata;
         end
      end
   end

   // configuration registers; the triggers are not stored
   always @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         flow_pri_ff   <= `RST_FLOW_PRI;
         flow_sec_ff   <= `RST_FLOW_SEC;
         tick_size_ff  <= `RST_TICK_SIZE;
         timer_coef_ff <= `RST_TIMER_COEF;
      end else if (wr_en) begin
         if (hit(I_WB_ADR, `IDX_FLOW_PRI)) begin
            flow_pri_ff <= I_WB_DAT[5:0];
         end
         if (hit(I_WB_ADR, `IDX_FLOW_SEC)) begin
            flow_sec_ff <= I_WB_DAT[7:0];
         end
         if (hit(I_WB_ADR, `IDX_TIMER_RES)) begin
            tick_size_ff <= I_WB_DAT[`TICK_HI:`TICK_LO];
         end
         if (hit(I_WB_ADR, `IDX_TIMER_COEF)) begin
            timer_coef_ff <= I_WB_DAT[7:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------------
   always @* begin
      nxt_state     = state_ff;
      nxt_mode      = mode_ff;
      nxt_init_mode = init_mode_ff;
      case (state_ff)
         ST_IDLE: begin
            // depth may change while resting; follow it live
            nxt_mode = rest_mode(rest_depth_select);
            if (t1_evt) begin
               nxt_state = rest_exit_route ? ST_RX : ST_TX;
               nxt_mode  = rest_exit_route ? `MODE_RX : `MODE_TX;
            end
         end
         ST_TX: begin
            if (I_FRAME_SENT_FLAG) begin
               if (send_exit_route) begin
                  nxt_state = ST_RX;
                  nxt_mode  = `MODE_RX;
               end else begin
                  nxt_state = lp_state(low_energy_choice);
                  nxt_mode  = lp_mode(low_energy_choice, rest_depth_select,
                                      init_mode_ff);
               end
            end
         end
         ST_RX: begin
            case (listen_exit_route)
               `LISTEN_BODY_PKT: begin
                  if (I_FRAME_BODY_COMPLETE) begin
                     nxt_state = ST_PKT_RX;
                  end
               end
               `LISTEN_BODY_LP: begin
                  if (I_FRAME_BODY_COMPLETE) begin
                     nxt_state = lp_state(low_energy_choice);
                     nxt_mode  = lp_mode(low_energy_choice, rest_depth_select,
                                         init_mode_ff);
                  end
               end
               `LISTEN_CHECK_PKT: begin
                  if (I_CHECK_PASS_FLAG) begin
                     nxt_state = ST_PKT_RX;
                  end
               end
               `LISTEN_RSSI_OFF: begin
                  if (I_RSSI_FLAG) begin
                     nxt_state = ST_OFF;
                  end
               end
               `LISTEN_SYNC_OFF: begin
                  if (I_SYNC_MATCH_FLAG) begin
                     nxt_state = ST_OFF;
                  end
               end
               `LISTEN_LEAD_OFF: begin
                  if (I_LEAD_IN_FOUND_FLAG) begin
                     nxt_state = ST_OFF;
                  end
               end
               // unused codes keep the sequencer receiving
               default: nxt_state = ST_RX;
            endcase
         end
         ST_WAIT_FIFO: begin
            if (I_QUEUE_THRESHOLD_FLAG) begin
               nxt_state = ST_TX;
               nxt_mode  = `MODE_TX;
            end
         end
         // off and packet-received hold until software acts
         default: nxt_state = state_ff;
      endcase

      // software owns the chip mode only while the sequencer is off
      if (state_ff == ST_OFF && wr_en && hit(I_WB_ADR, `IDX_OP_MODE)) begin
         nxt_mode = I_WB_DAT[2:0];
      end

      // start: only from off, and only with the chip in a low-power mode
      if (run_wr && state_ff == ST_OFF &&
          (mode_ff == `MODE_SLEEP || mode_ff == `MODE_STANDBY)) begin
         nxt_init_mode = mode_ff;
         case (I_WB_DAT[`LAUNCH_HI:`LAUNCH_LO])
            `LAUNCH_RX: begin
               nxt_state = ST_RX;
               nxt_mode  = `MODE_RX;
            end
            `LAUNCH_TX: begin
               nxt_state = ST_TX;
               nxt_mode  = `MODE_TX;
            end
            `LAUNCH_TX_FIFO: begin
               nxt_state = ST_WAIT_FIFO;
            end
            default: begin
               // route fields come from the same write
               nxt_state = lp_state(I_WB_DAT[`BIT_LOW_ENERGY]);
               nxt_mode  = lp_mode(I_WB_DAT[`BIT_LOW_ENERGY],
                                   I_WB_DAT[`BIT_REST_DEPTH], mode_ff);
            end
         endcase
      end

      // halt is applied last so its off state wins over run in the same write; the chip mode set by run still loads
      if (halt_wr) begin
         nxt_state = ST_OFF;
      end
   end

   // state, chip mode and captured initial mode
   always @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         state_ff     <= ST_OFF;
         mode_ff      <= `RST_OP_MODE;
         init_mode_ff <= `RST_OP_MODE;
      end else begin
         state_ff     <= nxt_state;
         mode_ff      <= nxt_mode;
         init_mode_ff <= nxt_init_mode;
      end
   end

   // ------------------------------------------------------------------
   // registered outputs, loaded from the next-state values in step with the state registers
   // ------------------------------------------------------------------
   always @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_CHIP_MODE <= `RST_OP_MODE;
         O_SEQ_STATE <= ST_OFF;
      end else begin
         O_CHIP_MODE <= nxt_mode;
         O_SEQ_STATE <= nxt_state;
      end
   end

endmodule

// [logic/seq_regs.vh]
/*
 * Register indices, field positions, reset values, chip mode codes and
 * timer tick counts for the top-level mode sequencer.
 * Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus
 * on which each register takes one aligned word at four times its index.
 */
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_OP_MODE       8'h01   // chip operating mode
`define IDX_FLOW_PRI      8'h36   // state_flow_control_primary
`define IDX_FLOW_SEC      8'h37   // state_flow_control_secondary
`define IDX_TIMER_RES     8'h38   // first timer tick size
`define IDX_TIMER_COEF    8'h39   // first timer tick count
`define IDX_SEQ_STATUS    8'h3a   // sequencer state and chip mode, read only

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_RUN           7       // run_trigger, write trigger
`define BIT_HALT          6       // halt_trigger, write trigger
`define BIT_REST_DEPTH    5       // rest_depth_select
`define LAUNCH_HI         4       // launch_route
`define LAUNCH_LO         3
`define BIT_LOW_ENERGY    2       // low_energy_choice
`define BIT_REST_EXIT     1       // rest_exit_route
`define BIT_SEND_EXIT     0       // send_exit_route
`define LISTEN_HI         7       // listen_exit_route
`define LISTEN_LO         5
`define TICK_HI           3       // first_timer_tick_size
`define TICK_LO           2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FLOW_PRI      6'h00
`define RST_FLOW_SEC      8'h00
`define RST_TICK_SIZE     2'h0
`define RST_TIMER_COEF    8'h01
`define RST_OP_MODE       3'h1

// ----------------------------------------------------------------------
// chip mode codes and field encodings
// ----------------------------------------------------------------------
`define MODE_SLEEP        3'h0
`define MODE_STANDBY      3'h1
`define MODE_TX           3'h3
`define MODE_RX           3'h5
`define LAUNCH_LOWPWR     2'h0
`define LAUNCH_RX         2'h1
`define LAUNCH_TX         2'h2
`define LAUNCH_TX_FIFO    2'h3
`define LISTEN_BODY_PKT   3'h1
`define LISTEN_BODY_LP    3'h2
`define LISTEN_CHECK_PKT  3'h3
`define LISTEN_RSSI_OFF   3'h4
`define LISTEN_SYNC_OFF   3'h5
`define LISTEN_LEAD_OFF   3'h6

// ----------------------------------------------------------------------
// timing: tick sizes in microseconds, cycles derived from the clock
// ----------------------------------------------------------------------
// sized to the timer width so the products need no silent truncation
`define CLK_MHZ           24'h000032  // 50 MHz
`define T1_RES1_US        24'h000040  // 64 us
`define T1_RES2_US        24'h001004  // 4.1 ms
`define T1_RES3_US        24'h03ff70  // 262 ms
`define T1_RES1_CYC       (`T1_RES1_US * `CLK_MHZ)
`define T1_RES2_CYC       (`T1_RES2_US * `CLK_MHZ)
`define T1_RES3_CYC       (`T1_RES3_US * `CLK_MHZ)

`endif

// [logic/first_timer.v]
/*
 * First timer of the sequencer: a tick divider with a selectable tick size
 * and a tick counter that pulses the timer-one event.
 * Assumes one 50 MHz clock; runs only while i_run is high.
 */
`include "seq_regs.vh"

module first_timer #(
   parameter [23:0] P_RES1_CYC = `T1_RES1_CYC,   // cycles per 64 us tick
   parameter [23:0] P_RES2_CYC = `T1_RES2_CYC,   // cycles per 4.1 ms tick
   parameter [23:0] P_RES3_CYC = `T1_RES3_CYC    // cycles per 262 ms tick
) (
   input  wire        i_clk,
   input  wire        i_reset,
   input  wire        i_run,
   input  wire [1:0]  i_tick_size,
   input  wire [7:0]  i_coef,
   output reg         o_event
);

   // ------------------------------------------------------------------
   // tick divider and tick counter
   // ------------------------------------------------------------------
   reg  [23:0] cyc_cnt_ff;   // cycles inside current tick
   reg  [7:0]  tick_cnt_ff;  // ticks since start or last event
   reg  [23:0] tick_len;     // selected tick length in cycles
   wire        tick_end;     // one-cycle enable at end of a tick
   wire        last_tick;    // this tick completes the period

   // tick length decode; code 0 disables the timer
   always @* begin
      case (i_tick_size)
         2'h1:    tick_len = P_RES1_CYC;
         2'h2:    tick_len = P_RES2_CYC;
         2'h3:    tick_len = P_RES3_CYC;
         default: tick_len = 24'h000000;
      endcase
   end

   assign tick_end  = (i_tick_size != 2'h0) && (cyc_cnt_ff == tick_len - 24'h000001);
   // a zero count is taken as one tick, so the event never stalls
   assign last_tick = (tick_cnt_ff + 8'h01 >= i_coef);

   // counters restart whenever the timer is stopped or disabled
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cyc_cnt_ff  <= 24'h000000;
         tick_cnt_ff <= 8'h00;
         o_event     <= 1'b0;
      end else if (!i_run || i_tick_size == 2'h0) begin
         cyc_cnt_ff  <= 24'h000000;
         tick_cnt_ff <= 8'h00;
         o_event     <= 1'b0;
      end else if (tick_end) begin
         cyc_cnt_ff  <= 24'h000000;
         tick_cnt_ff <= last_tick ? 8'h00 : tick_cnt_ff + 8'h01;
         o_event     <= last_tick;
      end else begin
         cyc_cnt_ff  <= cyc_cnt_ff + 24'h000001;
         o_event     <= 1'b0;
      end
   end

endmodule

// [verif/seq_properties.sv]
/* checker for the mode sequencer: bus handshake and state moves.
   assumes classic single-cycle wishbone masters and one-cycle event pulses */
module seq_properties (
   input wire logic        I_CORE_CLK,
   input wire logic        I_RESET,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [7:0]  I_WB_ADR,
   input wire logic [3:0]  I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   input wire logic        I_FRAME_SENT_FLAG,
   input wire logic        I_RSSI_FLAG,
   input wire logic        I_SYNC_MATCH_FLAG,
   input wire logic        I_LEAD_IN_FOUND_FLAG,
   input wire logic        O_WB_ACK,
   input wire logic [31:0] O_WB_DAT,
   input wire logic [2:0]  O_CHIP_MODE,
   input wire logic [2:0]  O_SEQ_STATE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] prim_ff;    // shadow of primary flow control
   logic [2:0] listen_ff;  // shadow of listen route
   logic       req;        // request not yet answered
   logic       off_evt;    // event that should end a receive
   assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   assign off_evt = (listen_ff == 3'h4 && I_RSSI_FLAG) || (listen_ff == 3'h5 && I_SYNC_MATCH_FLAG)
                    || (listen_ff == 3'h6 && I_LEAD_IN_FOUND_FLAG);
   // shadows follow writes at the ack edge, when the design commits them
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         prim_ff <= 8'h00;
         listen_ff <= 3'h0;
      end else if (O_WB_ACK && I_WB_WE && I_WB_SEL[0]) begin
         if (I_WB_ADR == 8'hd8) prim_ff <= I_WB_DAT[7:0];
         if (I_WB_ADR == 8'hdc) listen_ff <= I_WB_DAT[7:5];
      end
   end
   default clocking @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RESET);
   a_ack_one_cycle: assert property (req |=> O_WB_ACK)
      else $error("ack missing after request");
   a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (!req |=> !O_WB_ACK)
      else $error("ack without request");
   a_unmapped_zero: assert property (req && !I_WB_WE && I_WB_ADR > 8'he8 |=> O_WB_DAT == 32'h0)
      else $error("unmapped read not zero");
   a_trigger_reads_zero: assert property (
      req && !I_WB_WE && I_WB_ADR == 8'hd8 |=> O_WB_DAT[7:6] == 2'h0)
      else $error("trigger bits read back set");
   a_halt_goes_off: assert property (
      req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 8'hd8 && I_WB_DAT[6]
      |-> ##3 O_SEQ_STATE == 3'h0)
      else $error("halt did not reach off");
   a_rx_event_off: assert property (
      O_SEQ_STATE == 3'h3 && off_evt |-> ##2 O_SEQ_STATE == 3'h0)
      else $error("receive event did not reach off");
   a_tx_sent_rx: assert property (
      O_SEQ_STATE == 3'h2 && prim_ff[0] && I_FRAME_SENT_FLAG |-> ##2 O_SEQ_STATE == 3'h3)
      else $error("frame sent did not reach receive");
   // run from off with a low-power mode and route 01 lands in receive
   a_start_to_rx: assert property (
      req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 8'hd8 && I_WB_DAT[7:6] == 2'h2
      && I_WB_DAT[4:3] == 2'h1 && O_SEQ_STATE == 3'h0 && O_CHIP_MODE <= 3'h1
      |-> ##2 O_SEQ_STATE == 3'h3 && O_CHIP_MODE == 3'h5)
      else $error("start did not reach receive");
   // run with the chip outside sleep or standby leaves the sequencer off
   a_run_refused: assert property (
      req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 8'hd8 && I_WB_DAT[7]
      && O_SEQ_STATE == 3'h0 && O_CHIP_MODE > 3'h1 |-> ##2 O_SEQ_STATE == 3'h0)
      else $error("run accepted outside low power");
endmodule

// [verif/test_mode_sequencer.sv]
/* self-checking bench for the mode sequencer over wishbone.
   assumes one ack a cycle after each request and short tick parameters */
`include "seq_regs.vh"
module test_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, reset, cyc, stb, we, ack;
   logic [7:0]  adr, init, prim, code, m;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [6:0]  evt;       // sent, body, check, rssi, sync, lead-in, queue
   logic [2:0]  chip_mode, seq_state;
   int          err_count, total_checks, seed, n;
   mode_sequencer #(.P_RES1_CYC(24'h4), .P_RES2_CYC(24'h8), .P_RES3_CYC(24'h10))
   mode_sequencer_inst (.I_CORE_CLK(core_clk), .I_RESET(reset), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .I_FRAME_SENT_FLAG(evt[0]), .I_FRAME_BODY_COMPLETE(evt[1]), .I_CHECK_PASS_FLAG(evt[2]),
      .I_RSSI_FLAG(evt[3]), .I_SYNC_MATCH_FLAG(evt[4]), .I_LEAD_IN_FOUND_FLAG(evt[5]),
      .I_QUEUE_THRESHOLD_FLAG(evt[6]), .O_WB_ACK(ack), .O_WB_DAT(rdat),
      .O_CHIP_MODE(chip_mode), .O_SEQ_STATE(seq_state));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic end_of_test();
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; held until ack is sampled, then released a cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge core_clk);
      for (n = 0; ack !== 1'b1 && n < 50; n++) @(posedge core_clk);
      q = rdat;
      if (n >= 50) err_count++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, exp});
   endtask
   // halt, set the initial mode, then start with the given route fields
   task automatic start(input logic [7:0] md, input logic [7:0] p);
      bus(1'b1, 8'hd8, 8'h40);
      bus(1'b1, 8'h04, md);
      bus(1'b1, 8'hd8, 8'h80 | p);
      @(posedge core_clk);
   endtask
   task automatic pulse(input int i);
      evt[i] <= 1'b1;
      @(posedge core_clk);
      evt <= 7'h00;
      repeat (3) @(posedge core_clk);
   endtask
   // low-power selection outcome: {mode, state}
   function automatic logic [5:0] lp_exp(input logic [7:0] p, input logic [2:0] md);
      return p[2] ? {p[5] ? `MODE_SLEEP : `MODE_STANDBY, 3'h1} : {md, 3'h0};
   endfunction
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end
   initial begin
      {reset, seed, err_count, total_checks} = {1'b1, 32'hcabf, 64'h0};
      {cyc, stb, we, adr, sel, wdat, evt} = {3'h0, 8'h00, 4'hf, 32'h0, 7'h00};
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rdc(8'h04, 8'h01);
      rdc(8'hd8, 8'h00);
      rdc(8'hdc, 8'h00);
      rdc(8'he0, 8'h00);
      rdc(8'he4, 8'h01);
      rdc(8'he8, 8'h08);
      rdc(8'hfc, 8'h00);
      // start straight into low-power selection, random depth and choice
      repeat (4) begin
         init = $random(seed) & 1;
         prim = $random(seed) & 8'h24;
         start(init, prim);
         rdc(8'hd8, prim);
         rdc(8'he8, {2'h0, lp_exp(prim, init[2:0])});
      end
      // forced corner: idle in sleep, then depth cleared while resting
      start(`MODE_SLEEP, 8'h24);
      rdc(8'he8, {2'h0, lp_exp(8'h24, `MODE_SLEEP)});
      bus(1'b1, 8'hd8, 8'h04);
      rdc(8'he8, 8'h09);
      // idle exit on the first timer for tick sizes 1 to 3; size 0 stays in idle
      for (int ts = 0; ts < 4; ts++) begin
         bus(1'b1, 8'he0, ts[5:0] << 2);
         bus(1'b1, 8'he4, 8'h02);
         start(`MODE_STANDBY, 8'h04 | {6'h0, ts[0], 1'b0});
         for (int k = 0; seq_state === 3'h1 && k < 200; k++) @(posedge core_clk);
         chk({chip_mode, seq_state}, ts == 0 ? 6'h09 : ts[0] ? 6'h2b : 6'h1a);
      end
      bus(1'b1, 8'he0, 8'h00);
      // a write without the low byte lane is ignored
      sel <= 4'he;
      bus(1'b1, 8'he4, 8'h55);
      sel <= 4'hf;
      rdc(8'he4, 8'h02);
      // transmit exit on frame sent
      for (int s = 0; s < 2; s++) begin
         start(`MODE_SLEEP, 8'h14 | s[7:0]);
         chk(seq_state, 3'h2);
         pulse(0);
         chk({chip_mode, seq_state}, s ? 6'h2b : 6'h09);
      end
      // every listen route code, a foreign event first
      for (int c = 0; c < 8; c++) begin
         code = c;
         m = (c <= 2 || c >= 7) ? 8'h01 : code - 8'h01;
         bus(1'b1, 8'hdc, {code[2:0], 5'($random(seed))});
         init = $random(seed) & 1;
         start(init, 8'h08);
         chk(seq_state, 3'h3);
         pulse(m + 1);
         pulse(m);
         chk(seq_state, (c == 1 || c == 3) ? 3'h4 : (c == 0 || c == 7) ? 3'h3 : 3'h0);
         if (c == 2) chk(chip_mode, init[2:0]);
         if (c >= 4 && c <= 6) chk(chip_mode, `MODE_RX);
      end
      start(`MODE_STANDBY, 8'h18);
      chk(seq_state, 3'h5);
      pulse(6);
      chk({chip_mode, seq_state}, 6'h1a);
      // reset in mid-run while transmitting
      reset <= 1'b1;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk({chip_mode, seq_state}, 6'h08);
      rdc(8'hd8, 8'h00);
      start(`MODE_TX, 8'h08);
      chk(seq_state, 3'h0);
      start(`MODE_STANDBY, 8'h48);
      chk(seq_state, 3'h0);
      rdc(8'hd8, 8'h08);
      end_of_test();
   end
endmodule
bind mode_sequencer seq_properties seq_properties_inst (.I_CORE_CLK(I_CORE_CLK),
   .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
   .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
   .I_FRAME_SENT_FLAG(I_FRAME_SENT_FLAG), .I_RSSI_FLAG(I_RSSI_FLAG),
   .I_SYNC_MATCH_FLAG(I_SYNC_MATCH_FLAG), .I_LEAD_IN_FOUND_FLAG(I_LEAD_IN_FOUND_FLAG),
   .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT), .O_CHIP_MODE(O_CHIP_MODE),
   .O_SEQ_STATE(O_SEQ_STATE));
